// >>> qcr_pkg.sv
// shared constants and types for the quad channel clock and reset control
`default_nettype none
package qcr_pkg;
  localparam int NUM_CH = 4;
  localparam int DIV_W = 16;
  localparam int CH_C_INDEX = 2;
  localparam int FIFO_DEPTH = 128;
  localparam int MODEM_CTRL_PRESCALE_BIT = 7;
  localparam int CLK_PERIOD_NS = 50;
  localparam int RESET_MIN_NS = 40;
  localparam int RESET_MIN_CYC_RAW = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_MIN_CYC = (RESET_MIN_CYC_RAW < 1) ? 1 : RESET_MIN_CYC_RAW;
  localparam logic [1:0] RESET_MIN_CNT = 2'(RESET_MIN_CYC);
  localparam logic [1:0] RST_CNT_MAX = 2'h3;
  localparam logic [1:0] PWRUP_HOLD_CNT = 2'h3;
  localparam logic [1:0] PRESCALE_DIV1_LAST = 2'h0;
  localparam logic [1:0] PRESCALE_DIV4_LAST = 2'h3;
  localparam logic [DIV_W-1:0] DIV_RELOAD_EDGE = 16'h0001;

  typedef enum logic [2:0] {
    QCR_RS_POWERUP = 3'h1,
    QCR_RS_HELD = 3'h2,
    QCR_RS_RUN = 3'h4
  } qcr_rst_state_t;
endpackage : qcr_pkg
`default_nettype wire

// >>> qcr_brg_if.sv
// link between the control logic and one channel baud generator
`timescale 1ns/1ps
`default_nettype none
interface qcr_brg_if;
  import qcr_pkg::*;
  logic dev_rst;
  logic src_tick;
  logic div4;
  logic [DIV_W-1:0] divisor;
  logic tick;
  logic bclk;
  modport gen (input dev_rst, input src_tick, input div4, input divisor, output tick, output bclk);
  modport ctl (output dev_rst, output src_tick, output div4, output divisor, input tick, input bclk);
endinterface : qcr_brg_if
`default_nettype wire

// >>> qcr_baud_gen.sv
// one channel baud generator: prescaler then divisor, 16x tick and clock out
`timescale 1ns/1ps
`default_nettype none
module qcr_baud_gen (
  input wire logic clk,
  input wire logic rst_n,
  qcr_brg_if.gen brg
);
  import qcr_pkg::*;

  typedef struct packed {
    logic [1:0] pre_cnt;
    logic [DIV_W-1:0] cnt;
    logic tick;
    logic bclk;
  } qcr_brg_state_t;

  localparam qcr_brg_state_t BRG_RESET = '{default: '0};

  qcr_brg_state_t st_reg;
  qcr_brg_state_t st_next;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [1:0] pre_last;
    pre_last = brg.div4 ? PRESCALE_DIV4_LAST : PRESCALE_DIV1_LAST;
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (brg.dev_rst) begin
      st_next = BRG_RESET;
    end else if (brg.src_tick) begin
      if (st_reg.pre_cnt >= pre_last) begin
        st_next.pre_cnt = '0;
        if (st_reg.cnt <= DIV_RELOAD_EDGE) begin
          st_next.cnt = brg.divisor;
          st_next.tick = 1'b1;
        end else begin
          st_next.cnt = DIV_W'(st_reg.cnt - DIV_RELOAD_EDGE);
        end
      end else begin
        st_next.pre_cnt = 2'(st_reg.pre_cnt + 2'h1);
      end
    end
    // high for the upper half of the count, square at even divisors
    st_next.bclk = !brg.dev_rst && (st_next.cnt > {1'b0, brg.divisor[DIV_W-1:1]});
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= BRG_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign brg.tick = st_reg.tick;
  assign brg.bclk = st_reg.bclk;
endmodule : qcr_baud_gen
`default_nettype wire

// >>> qcr_clock_reset_ctrl.sv
// shared straps, reset, prescale and baud clocks of the four channel uart
//
// Operation
// - strap high Intel bus, low Motorola bus
// - prescale strap sampled only during reset
// - strap high divide by 1, low by 4
// - modem control bit 7 overrides prescale later
// - each channel drives 16x baud clock out
// - channel C clocked from its dedicated input
// - Intel mode reset active high, 40 ns
// - in reset, transmit high, receive ignored
// - Motorola mode reset active low, 40 ns
// - strobes and select all low: factory test
// - four channels, each its own registers
// - each channel has 128-byte fifos
`timescale 1ns/1ps
`default_nettype none
module qcr_clock_reset_ctrl (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic BUS_STYLE_STRAP,
  input wire logic PRESCALE_STRAP,
  input wire logic RESET_PIN,
  input wire logic READ_STROBE_N,
  input wire logic WRITE_STROBE_N,
  input wire logic [qcr_pkg::NUM_CH-1:0] CHIP_SELECT_N,
  input wire logic THIRD_CHANNEL_CLOCK_IN,
  input wire logic [qcr_pkg::NUM_CH-1:0] MODEM_CONTROL_WE,
  input wire logic [7:0] MODEM_CONTROL_WDATA,
  input wire logic [qcr_pkg::NUM_CH*qcr_pkg::DIV_W-1:0] BAUD_DIVISOR,
  input wire logic [qcr_pkg::NUM_CH-1:0] CHANNEL_TX_IN,
  input wire logic [qcr_pkg::NUM_CH-1:0] SERIAL_RX_IN,
  output logic OSCILLATOR_OUT,
  output logic BAUD_CLOCK_OUT_A,
  output logic BAUD_CLOCK_OUT_B,
  output logic BAUD_CLOCK_OUT_C,
  output logic BAUD_CLOCK_OUT_D,
  output logic [qcr_pkg::NUM_CH-1:0] BAUD_TICK,
  output logic [qcr_pkg::NUM_CH-1:0] SERIAL_TX_OUT,
  output logic [qcr_pkg::NUM_CH-1:0] CHANNEL_RX_OUT,
  output logic [qcr_pkg::NUM_CH-1:0] PRESCALE_DIV4,
  output logic INTEL_MODE,
  output logic DEVICE_RESET,
  output logic FACTORY_TEST
);
  import qcr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic qcr_reset_level(input logic intel, input logic level);
    qcr_reset_level = intel ? level : !level;
  endfunction : qcr_reset_level

  function automatic logic qcr_selected(input logic intel, input logic [NUM_CH-1:0] cs_n);
    // Motorola style has a single select on the first line
    qcr_selected = intel ? !(&cs_n) : !cs_n[0];
  endfunction : qcr_selected

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic bus_meta;
    logic bus_sync;
    logic ps_meta;
    logic ps_sync;
    logic rpin_meta;
    logic rpin_sync;
    logic rd_meta;
    logic rd_sync;
    logic wr_meta;
    logic wr_sync;
    logic [NUM_CH-1:0] cs_meta;
    logic [NUM_CH-1:0] cs_sync;
    logic chc_meta;
    logic chc_sync;
    logic chc_prev;
    logic chc_tick;
    logic [NUM_CH-1:0] rx_meta;
    logic [NUM_CH-1:0] rx_sync;
    qcr_rst_state_t rst_state;
    logic [1:0] pwr_cnt;
    logic [1:0] rst_cnt;
    logic dev_rst;
    logic intel_mode;
    logic strap_div4;
    logic [NUM_CH-1:0] ovr_valid;
    logic [NUM_CH-1:0] ovr_div4;
    logic [NUM_CH-1:0] eff_div4;
    logic [NUM_CH-1:0] tx_out;
    logic [NUM_CH-1:0] rx_out;
    logic factory_test;
    logic osc_out;
  } qcr_ctl_state_t;

  localparam qcr_ctl_state_t CTL_RESET = '{
    bus_meta: 1'b1,
    bus_sync: 1'b1,
    ps_meta: 1'b1,
    ps_sync: 1'b1,
    rpin_meta: 1'b0,
    rpin_sync: 1'b0,
    rd_meta: 1'b1,
    rd_sync: 1'b1,
    wr_meta: 1'b1,
    wr_sync: 1'b1,
    cs_meta: '1,
    cs_sync: '1,
    chc_meta: 1'b0,
    chc_sync: 1'b0,
    chc_prev: 1'b0,
    chc_tick: 1'b0,
    rx_meta: '1,
    rx_sync: '1,
    rst_state: QCR_RS_POWERUP,
    pwr_cnt: 2'h0,
    rst_cnt: 2'h0,
    dev_rst: 1'b1,
    intel_mode: 1'b1,
    strap_div4: 1'b0,
    ovr_valid: '0,
    ovr_div4: '0,
    eff_div4: '0,
    tx_out: '1,
    rx_out: '1,
    factory_test: 1'b0,
    osc_out: 1'b0
  };

  qcr_ctl_state_t st_reg;
  qcr_ctl_state_t st_next;
  logic rst_meta_reg;
  logic rst_sync_reg;

  ////////////////////////////////////////////////////////////////////////////
  // power-on reset release

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic pin_active;
    logic qualified;
    pin_active = 1'b0;
    qualified = 1'b0;
    st_next = st_reg;

    // every strap, strobe, select, reset pin, channel C clock and receive pin passes two flops before use
    st_next.bus_meta = BUS_STYLE_STRAP;
    st_next.bus_sync = st_reg.bus_meta;
    st_next.ps_meta = PRESCALE_STRAP;
    st_next.ps_sync = st_reg.ps_meta;
    st_next.rpin_meta = RESET_PIN;
    st_next.rpin_sync = st_reg.rpin_meta;
    st_next.rd_meta = READ_STROBE_N;
    st_next.rd_sync = st_reg.rd_meta;
    st_next.wr_meta = WRITE_STROBE_N;
    st_next.wr_sync = st_reg.wr_meta;
    st_next.cs_meta = CHIP_SELECT_N;
    st_next.cs_sync = st_reg.cs_meta;
    st_next.chc_meta = THIRD_CHANNEL_CLOCK_IN;
    st_next.chc_sync = st_reg.chc_meta;
    st_next.rx_meta = SERIAL_RX_IN;
    st_next.rx_sync = st_reg.rx_meta;

    st_next.intel_mode = st_reg.bus_sync;

    // reset pin polarity follows the bus style
    pin_active = qcr_reset_level(st_reg.bus_sync, st_reg.rpin_sync);
    if (!pin_active) begin
      st_next.rst_cnt = 2'h0;
    end else if (st_reg.rst_cnt != RST_CNT_MAX) begin
      st_next.rst_cnt = 2'(st_reg.rst_cnt + 2'h1);
    end
    // pulse shorter than one clock may be missed: the clock is the limit
    qualified = pin_active && (st_next.rst_cnt >= RESET_MIN_CNT);

    case (st_reg.rst_state)
      QCR_RS_POWERUP: begin
        // hold until the strap synchronisers carry real pin levels
        st_next.pwr_cnt = 2'(st_reg.pwr_cnt + 2'h1);
        if (st_reg.pwr_cnt == PWRUP_HOLD_CNT) begin
          st_next.rst_state = qualified ? QCR_RS_HELD : QCR_RS_RUN;
        end
      end
      QCR_RS_HELD: begin
        if (!pin_active) begin
          st_next.rst_state = QCR_RS_RUN;
        end
      end
      QCR_RS_RUN: begin
        if (qualified) begin
          st_next.rst_state = QCR_RS_HELD;
        end
      end
      default: begin
        st_next.rst_state = QCR_RS_POWERUP;
      end
    endcase
    // resets every channel register set and its 128-byte fifos
    st_next.dev_rst = (st_next.rst_state != QCR_RS_RUN);

    if (st_reg.dev_rst) begin
      st_next.strap_div4 = !st_reg.ps_sync;
      st_next.ovr_valid = '0;
      st_next.ovr_div4 = '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (MODEM_CONTROL_WE[i]) begin
          st_next.ovr_valid[i] = 1'b1;
          st_next.ovr_div4[i] = MODEM_CONTROL_WDATA[MODEM_CTRL_PRESCALE_BIT];
        end
      end
    end
    for (int i = 0; i < NUM_CH; i++) begin
      if (st_next.ovr_valid[i]) begin
        st_next.eff_div4[i] = st_next.ovr_div4[i];
      end else begin
        // strap ratio stands until software writes this channel
        st_next.eff_div4[i] = st_next.strap_div4;
      end
    end

    // line idle while reset stands, receive data discarded
    if (st_next.dev_rst) begin
      st_next.tx_out = '1;
      st_next.rx_out = '1;
    end else begin
      st_next.tx_out = CHANNEL_TX_IN;
      st_next.rx_out = st_reg.rx_sync;
    end

    // a plain level, no latch: test mode ends once a strobe rises or the decoded select goes inactive
    st_next.factory_test = !st_reg.rd_sync && !st_reg.wr_sync
      && qcr_selected(st_reg.bus_sync, st_reg.cs_sync);

    // rising edge of the dedicated input drives channel C
    // prev resets low like the idle oscillator copy, so no false edge
    st_next.chc_prev = st_reg.chc_sync;
    st_next.chc_tick = st_reg.chc_sync && !st_reg.chc_prev;

    // buffered oscillator copy at half rate, kept on a flop
    st_next.osc_out = !st_reg.osc_out;
  end

  always_ff @(posedge CLK or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      st_reg <= CTL_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // channel baud generators

  qcr_brg_if brg_if [NUM_CH] ();
  logic [NUM_CH-1:0] bclk_w;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      assign brg_if[gi].dev_rst = st_reg.dev_rst;
      // others run off the oscillator; the input needs at most half CLK rate
      assign brg_if[gi].src_tick = (gi == CH_C_INDEX) ? st_reg.chc_tick : 1'b1;
      assign brg_if[gi].div4 = st_reg.eff_div4[gi];
      assign brg_if[gi].divisor = BAUD_DIVISOR[gi*DIV_W +: DIV_W];
      assign BAUD_TICK[gi] = brg_if[gi].tick;
      assign bclk_w[gi] = brg_if[gi].bclk;
      qcr_baud_gen u_brg (
        .clk(CLK),
        .rst_n(rst_sync_reg),
        .brg(brg_if[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign BAUD_CLOCK_OUT_A = bclk_w[0];
  assign BAUD_CLOCK_OUT_B = bclk_w[1];
  assign BAUD_CLOCK_OUT_C = bclk_w[2];
  assign BAUD_CLOCK_OUT_D = bclk_w[3];
  assign OSCILLATOR_OUT = st_reg.osc_out;
  assign SERIAL_TX_OUT = st_reg.tx_out;
  assign CHANNEL_RX_OUT = st_reg.rx_out;
  assign PRESCALE_DIV4 = st_reg.eff_div4;
  assign INTEL_MODE = st_reg.intel_mode;
  assign DEVICE_RESET = st_reg.dev_rst;
  assign FACTORY_TEST = st_reg.factory_test;
endmodule : qcr_clock_reset_ctrl
`default_nettype wire

// >>> qcr_clock_reset_ctrl_chk.sv
// port assertions for the clock and reset control
`timescale 1ns/1ps
`default_nettype none
module qcr_clock_reset_ctrl_chk (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic RESET_PIN,
  input wire logic READ_STROBE_N,
  input wire logic WRITE_STROBE_N,
  input wire logic [qcr_pkg::NUM_CH-1:0] CHIP_SELECT_N,
  input wire logic [qcr_pkg::NUM_CH-1:0] MODEM_CONTROL_WE,
  input wire logic [7:0] MODEM_CONTROL_WDATA,
  input wire logic [qcr_pkg::NUM_CH-1:0] CHANNEL_TX_IN,
  input wire logic [qcr_pkg::NUM_CH-1:0] SERIAL_TX_OUT,
  input wire logic [qcr_pkg::NUM_CH-1:0] CHANNEL_RX_OUT,
  input wire logic [qcr_pkg::NUM_CH-1:0] PRESCALE_DIV4,
  input wire logic INTEL_MODE,
  input wire logic DEVICE_RESET,
  input wire logic FACTORY_TEST
);
  import qcr_pkg::*;
  logic rst_act;
  logic tst;
  // pin polarity follows bus style
  assign rst_act = INTEL_MODE ? RESET_PIN : !RESET_PIN;
  assign tst = !READ_STROBE_N && !WRITE_STROBE_N && (INTEL_MODE ? (CHIP_SELECT_N != 4'hF) : !CHIP_SELECT_N[0]);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);
  ////////////////////////////////////////
  chk_tx_follow: assert property (!DEVICE_RESET && !$past(DEVICE_RESET) && !$past(DEVICE_RESET, 2)
    |-> SERIAL_TX_OUT == $past(CHANNEL_TX_IN)) else $error("transmit out does not follow data");
  chk_tx_idle: assert property (DEVICE_RESET && $past(DEVICE_RESET) |-> SERIAL_TX_OUT == 4'hF)
    else $error("transmit out not idle in reset");
  chk_rx_blocked: assert property (DEVICE_RESET && $past(DEVICE_RESET) |-> CHANNEL_RX_OUT == 4'hF)
    else $error("receive input passed in reset");
  chk_div4_hold: assert property (!DEVICE_RESET && !$past(DEVICE_RESET) && !$past(DEVICE_RESET, 2)
    && $past(MODEM_CONTROL_WE) == 4'h0 |-> $stable(PRESCALE_DIV4)) else $error("prescale moved without write");
  chk_modem_override: assert property (!DEVICE_RESET && !$past(DEVICE_RESET) && MODEM_CONTROL_WE != 4'h0
    |=> (PRESCALE_DIV4 & $past(MODEM_CONTROL_WE))
    == ($past(MODEM_CONTROL_WDATA[MODEM_CTRL_PRESCALE_BIT]) ? $past(MODEM_CONTROL_WE) : 4'h0))
    else $error("override bit not applied");
  chk_test_entry: assert property (tst [*3] |=> FACTORY_TEST) else $error("test mode not entered");
  chk_test_exit: assert property ((!tst) [*3] |=> !FACTORY_TEST) else $error("test mode not left");
  chk_rst_entry: assert property ($rose(rst_act) ##1 rst_act |-> ##[0:4] DEVICE_RESET)
    else $error("reset pin ignored");
  chk_rst_exit: assert property ($fell(rst_act) ##1 !rst_act |-> ##[0:4] !DEVICE_RESET)
    else $error("reset did not end");
endmodule : qcr_clock_reset_ctrl_chk
`default_nettype wire

// >>> qcr_host_model.sv
// host side: reset pin, strobes, selects, channel c clock source
`timescale 1ns/1ps
`default_nettype none
module qcr_host_model (
  input wire logic clk,
  input wire logic osc_out,
  output logic reset_pin,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic [3:0] chip_select_n,
  output logic ch_c_clk
);
  logic ext_sel = 1'b0;
  logic [2:0] ext_cnt = 3'h0;
  initial begin
    reset_pin = 1'b0;
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    chip_select_n = 4'hF;
  end
  always @(posedge clk) ext_cnt <= ext_cnt + 3'h1;
  // board feeds channel c from oscillator or a slower external clock
  assign ch_c_clk = ext_sel ? ext_cnt[2] : osc_out;
  task automatic pulse_reset(input logic act, input int cyc);
    @(posedge clk);
    #1 reset_pin = act;
    repeat (cyc) @(posedge clk);
    #1 reset_pin = ~act;
  endtask : pulse_reset
  // all three low only when the bench asks for test mode
  task automatic drive_bus(input logic rd_n, input logic wr_n, input logic [3:0] cs_n);
    @(posedge clk);
    #1 read_strobe_n = rd_n;
    write_strobe_n = wr_n;
    chip_select_n = cs_n;
  endtask : drive_bus
endmodule : qcr_host_model
`default_nettype wire

// >>> qcr_clock_reset_ctrl_tb.sv
// self-checking bench for the clock and reset control
`timescale 1ns/1ps
`default_nettype none
module qcr_clock_reset_ctrl_tb;
  import qcr_pkg::*;
  logic clk, reset_n, bus_strap, pre_strap;
  logic [3:0] mc_we, tx_in, rx_in;
  logic [7:0] mc_wdata;
  wire rst_pin, rd_n, wr_n, ch_c_clk, osc, intel, dev_rst, ftest;
  wire [3:0] cs_n, bclk, tick, tx_out, rx_out, div4;
  int bad_count = 0;
  int num_checks = 0;
  int cyc = 0;
  qcr_clock_reset_ctrl u_dut (.CLK(clk), .RESET_N(reset_n), .BUS_STYLE_STRAP(bus_strap),
    .PRESCALE_STRAP(pre_strap), .RESET_PIN(rst_pin), .READ_STROBE_N(rd_n), .WRITE_STROBE_N(wr_n),
    .CHIP_SELECT_N(cs_n), .THIRD_CHANNEL_CLOCK_IN(ch_c_clk), .MODEM_CONTROL_WE(mc_we),
    .MODEM_CONTROL_WDATA(mc_wdata), .BAUD_DIVISOR({16'h0005, 16'h0003, 16'h0003, 16'h0002}), .CHANNEL_TX_IN(tx_in),
    .SERIAL_RX_IN(rx_in), .OSCILLATOR_OUT(osc), .BAUD_CLOCK_OUT_A(bclk[0]), .BAUD_CLOCK_OUT_B(bclk[1]),
    .BAUD_CLOCK_OUT_C(bclk[2]), .BAUD_CLOCK_OUT_D(bclk[3]), .BAUD_TICK(tick), .SERIAL_TX_OUT(tx_out),
    .CHANNEL_RX_OUT(rx_out), .PRESCALE_DIV4(div4), .INTEL_MODE(intel), .DEVICE_RESET(dev_rst),
    .FACTORY_TEST(ftest));
  qcr_host_model u_host (.clk(clk), .osc_out(osc), .reset_pin(rst_pin), .read_strobe_n(rd_n),
    .write_strobe_n(wr_n), .chip_select_n(cs_n), .ch_c_clk(ch_c_clk));
  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count = bad_count + 1;
      print_verdict();
    end
  end
  task automatic print_verdict();
    if (bad_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic chk_bits(input logic [3:0] got, input logic [3:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_bits
  task automatic chk_count(input int got, input int exp);
    num_checks++;
    if (got != exp) begin
      bad_count++;
      $display("mismatch at %0t: period %0d expected %0d", $time, got, exp);
    end
  endtask : chk_count
  // bounded wait on the device reset level
  task automatic wait_dev(input logic lvl);
    int n = 0;
    while (dev_rst !== lvl && n < 20) begin
      step(1);
      n++;
    end
    chk_bits({3'h0, dev_rst}, {3'h0, lvl});
  endtask : wait_dev
  // tick spacing of one channel, and both clock levels seen in it
  task automatic measure(input int ch, input int exp);
    int n = 0;
    int per = 0;
    logic [1:0] seen = 2'h0;
    while (tick[ch] !== 1'b1 && n < 400) begin
      step(1);
      n++;
    end
    do begin
      step(1);
      per++;
      seen = seen | {bclk[ch], !bclk[ch]};
    end while (tick[ch] !== 1'b1 && per < 400);
    chk_count(per, exp);
    chk_bits({2'h0, seen}, 4'h3);
  endtask : measure
  ////////////////////////////////////////
  task automatic t_power_up();
    step(10);
    chk_bits(tx_out, 4'hF);
    reset_n = 1'b1;
    wait_dev(1'b0);
    chk_bits({3'h0, intel}, 4'h1);
    chk_bits(div4, 4'hF);
  endtask : t_power_up
  task automatic t_strap_relatch();
    pre_strap = 1'b1;
    step(6);
    chk_bits(div4, 4'hF);
    u_host.pulse_reset(1'b1, 5);
    wait_dev(1'b1);
    step(1);
    chk_bits(tx_out, 4'hF);
    chk_bits(rx_out, 4'hF);
    wait_dev(1'b0);
    step(2);
    chk_bits(div4, 4'h0);
  endtask : t_strap_relatch
  task automatic t_override();
    mc_we = 4'h5;
    mc_wdata = 8'h80;
    step(1);
    chk_bits(div4, 4'h5);
    mc_we = 4'h1;
    mc_wdata = 8'h7F;
    step(1);
    mc_we = 4'h2;
    mc_wdata = 8'h80;
    step(1);
    mc_we = 4'h0;
    step(3);
    chk_bits(div4, 4'h6);
  endtask : t_override
  task automatic t_baud();
    measure(0, 2);
    measure(1, 12);
    measure(2, 24);
    measure(3, 5);
    u_host.ext_sel = 1'b1;
    step(20);
    measure(2, 96);
  endtask : t_baud
  task automatic t_serial();
    tx_in = 4'hA;
    step(1);
    chk_bits(tx_out, 4'hA);
    rx_in = 4'h5;
    step(4);
    chk_bits(rx_out, 4'h5);
  endtask : t_serial
  task automatic t_factory();
    u_host.drive_bus(1'b0, 1'b0, 4'hB);
    step(4);
    chk_bits({3'h0, ftest}, 4'h1);
    u_host.drive_bus(1'b0, 1'b1, 4'h0);
    step(4);
    chk_bits({3'h0, ftest}, 4'h0);
  endtask : t_factory
  task automatic t_motorola();
    bus_strap = 1'b0;
    wait_dev(1'b1);
    chk_bits({3'h0, intel}, 4'h0);
    u_host.reset_pin = 1'b1;
    wait_dev(1'b0);
    u_host.pulse_reset(1'b0, 2);
    wait_dev(1'b1);
    wait_dev(1'b0);
    u_host.drive_bus(1'b0, 1'b0, 4'h1);
    step(4);
    chk_bits({3'h0, ftest}, 4'h0);
    u_host.drive_bus(1'b0, 1'b0, 4'hE);
    step(4);
    chk_bits({3'h0, ftest}, 4'h1);
    u_host.drive_bus(1'b1, 1'b1, 4'hF);
    step(4);
  endtask : t_motorola
  initial begin
    reset_n = 1'b0;
    bus_strap = 1'b1;
    pre_strap = 1'b0;
    mc_we = 4'h0;
    mc_wdata = 8'h00;
    tx_in = 4'h0;
    rx_in = 4'h0;
    t_power_up();
    t_strap_relatch();
    t_override();
    t_baud();
    t_serial();
    t_factory();
    t_motorola();
    print_verdict();
  end
endmodule : qcr_clock_reset_ctrl_tb
bind qcr_clock_reset_ctrl qcr_clock_reset_ctrl_chk u_chk (.CLK(CLK), .RESET_N(RESET_N), .RESET_PIN(RESET_PIN),
  .READ_STROBE_N(READ_STROBE_N), .WRITE_STROBE_N(WRITE_STROBE_N), .CHIP_SELECT_N(CHIP_SELECT_N),
  .MODEM_CONTROL_WE(MODEM_CONTROL_WE), .MODEM_CONTROL_WDATA(MODEM_CONTROL_WDATA), .CHANNEL_TX_IN(CHANNEL_TX_IN),
  .SERIAL_TX_OUT(SERIAL_TX_OUT), .CHANNEL_RX_OUT(CHANNEL_RX_OUT), .PRESCALE_DIV4(PRESCALE_DIV4),
  .INTEL_MODE(INTEL_MODE), .DEVICE_RESET(DEVICE_RESET), .FACTORY_TEST(FACTORY_TEST));
`default_nettype wire
